// [verilog/fcs_flash_command_sequencer.v]
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

module fcs_flash_command_sequencer #(
  // Long operation counts, shortenable in simulation.
  // A shortened count never cuts an erase or a signature short: those
  // also wait for their address walk, so only the padding shrinks.
  parameter integer WRITE_CYC = (`FCS_WRITE_US * 1000) / `FCS_CLK_NS,
  parameter integer ERWR_CYC  = (`FCS_ERWR_MS * 1000000) / `FCS_CLK_NS,
  parameter integer ERASE_CYC = (`FCS_ERASE_MS * 1000000) / `FCS_CLK_NS,
  parameter integer MASS_CYC  = (`FCS_MASS_MS * 1000000) / `FCS_CLK_NS,
  parameter integer SIGN_CYC  = `FCS_SIGN_CYC
) (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        clkEn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         irq
);

  // ==========================================================
  // State encodings, one-hot.
  // ==========================================================
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_WAIT = 4'b0010;
  localparam [3:0] S_SIGN = 4'b0100;
  localparam [3:0] S_DONE = 4'b1000;
  // Read, verify, protect and reserved codes pass through the wait state
  // for one cycle, so every command ends the same way.

  // Flash array; 32k words of 16 bits.
  reg [15:0] flashMem [0:(1<<`FCS_AW)-1];
  // The array has no reset, since its contents must outlive one; words
  // that were never erased start out unknown.

  // Bus address phase capture.
  reg        wrPend_reg;
  reg        rdPend_reg;
  reg [7:0]  regAddr_reg;

  // Software-visible registers.
  reg [15:0] flash_data_reg;
  reg [15:0] flash_address_reg;
  reg [23:0] flash_signature_reg;
  reg [31:0] flash_protection_value;
  reg        protectUsed_reg;      // Protect has already run.
  reg [3:0]  status_reg;           // Sticky events plus busy.
  reg [3:0]  irqMask_reg;          // Same layout as status.
  reg [7:0]  mode_reg;             // Sequencer enable in bit 0.
  reg        massArmed_reg;        // Key written, mass erase allowed.

  // Sequencer state.
  reg [3:0]  state_reg;
  reg [3:0]  cmd_reg;
  reg [31:0] count_reg;
  reg [`FCS_AW-1:0] sweep_reg;     // Address walk for erase and signature.
  reg        sweepOn_reg;

  // Word address and page range of the current command.
  wire [`FCS_AW-1:0] wordAddr  = flash_address_reg[`FCS_AW:1];
  wire [`FCS_AW-1:0] pageBase  = {wordAddr[`FCS_AW-1:`FCS_PAGE_SH], {`FCS_PAGE_SH{1'b0}}};
  wire [`FCS_AW-1:0] pageLast  = {wordAddr[`FCS_AW-1:`FCS_PAGE_SH], {`FCS_PAGE_SH{1'b1}}};

  // Only whole-word transfers are used, so the transfer size is not
  // decoded; a narrower write still lands as a full word.
  // Bus decode in the address phase.
  wire addrPhase = hsel & htrans[1] & hready;
  wire busWr     = wrPend_reg;
  wire cmdWrite  = busWr & (regAddr_reg == `FCS_OFF_COMMAND);
  wire idle      = state_reg[0];

  // Event pulses from the sequencer, into the status register.
  // They last one cycle and are registered, so status lags the event by one.
  reg [3:0] evSet;

  // ==========================================================
  // Bus slave: single-cycle address phase, zero-wait data phase.
  // The slave never stalls and never errors, so hreadyout and hresp
  // are constants held in flops to keep every output registered.
  // ==========================================================
  always @(posedge core_clk) begin
    if (!resetn) begin
      wrPend_reg  <= 1'b0;
      rdPend_reg  <= 1'b0;
      regAddr_reg <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else if (clkEn) begin
      // Capture the request; the data phase always finishes next cycle.
      wrPend_reg  <= addrPhase & hwrite;
      rdPend_reg  <= addrPhase & ~hwrite;
      regAddr_reg <= haddr[7:0];
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  // Read data is registered during the address phase so it stands in the data phase.
  // Outside a data phase it returns to zero, so stale words never linger
  // on the bus.
  always @(posedge core_clk) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clkEn) begin
      if (addrPhase & ~hwrite) begin
        case (haddr[7:0])
          `FCS_OFF_STATUS:    hrdata <= {28'h000_0000, status_reg};
          `FCS_OFF_MODE:      hrdata <= {24'h00_0000, mode_reg};
          `FCS_OFF_COMMAND:   hrdata <= {28'h000_0000, cmd_reg};
          `FCS_OFF_DATA:      hrdata <= {16'h0000, flash_data_reg};
          `FCS_OFF_ADDRESS:   hrdata <= {16'h0000, flash_address_reg};
          `FCS_OFF_SIGNATURE: hrdata <= {8'h00, flash_signature_reg};
          `FCS_OFF_PROTECT:   hrdata <= flash_protection_value;
          `FCS_OFF_IRQ_MASK:  hrdata <= {28'h000_0000, irqMask_reg};
          // Unmapped and write-only addresses read zero.
          default:            hrdata <= 32'h0000_0000;
        endcase
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Sequencer: one process owns the flash array and data registers.
  // A single writer keeps the array free of write races; bus writes to
  // data and address are taken here too, so a command sees them settled.
  // ==========================================================
  always @(posedge core_clk) begin
    if (!resetn) begin
      state_reg              <= S_IDLE;
      cmd_reg                <= 4'h0;
      count_reg              <= 32'h0000_0000;
      sweep_reg              <= {`FCS_AW{1'b0}};
      sweepOn_reg            <= 1'b0;
      flash_data_reg         <= 16'h0000;
      flash_address_reg      <= 16'h0000;
      flash_signature_reg    <= 24'h00_0000;
      flash_protection_value <= 32'hFFFF_FFFF;
      protectUsed_reg        <= 1'b0;
      massArmed_reg          <= 1'b0;
      mode_reg               <= 8'h01;
      irqMask_reg            <= 4'h0;
      evSet                  <= 4'h0;
    end else if (clkEn) begin
      evSet <= 4'h0;
      // Plain register writes; data and address are locked while busy.
      if (busWr) begin
        case (regAddr_reg)
          `FCS_OFF_MODE:     mode_reg    <= hwdata[7:0];
          `FCS_OFF_IRQ_MASK: irqMask_reg <= hwdata[3:0];
          `FCS_OFF_DATA:     if (idle) flash_data_reg <= hwdata[15:0];
          `FCS_OFF_ADDRESS:  if (idle) flash_address_reg <= hwdata[15:0];
          `FCS_OFF_PROTECT:  if (idle && !protectUsed_reg) flash_protection_value <= hwdata;
          `FCS_OFF_KEY:      massArmed_reg <= (hwdata[15:0] == `FCS_MASS_KEY);
          default: ;
        endcase
      end
      case (state_reg)
        S_IDLE: begin
          // accept only when idle
          // A command write in any other state is dropped without trace.
          if (cmdWrite && mode_reg[0]) begin
            cmd_reg <= hwdata[3:0];
            massArmed_reg <= 1'b0;
            state_reg <= S_WAIT;
            count_reg <= 32'h0000_0001;
            sweepOn_reg <= 1'b0;
            case (hwdata[3:0])
              `FCS_CMD_READ: flash_data_reg <= flashMem[wordAddr];
              `FCS_CMD_WRITE: begin
                flashMem[wordAddr] <= flashMem[wordAddr] & flash_data_reg;
                count_reg <= WRITE_CYC;
              end
              `FCS_CMD_ERWR: begin
                sweep_reg <= pageBase;
                sweepOn_reg <= 1'b1;
                count_reg <= ERWR_CYC;
              end
              `FCS_CMD_VERIFY: begin
                evSet[`FCS_ST_VERIFY] <= (flashMem[wordAddr] != flash_data_reg);
              end
              `FCS_CMD_PGERASE: begin
                sweep_reg <= pageBase;
                sweepOn_reg <= 1'b1;
                count_reg <= ERASE_CYC;
              end
              `FCS_CMD_MASS: begin
                if (massArmed_reg) begin
                  sweep_reg <= {`FCS_AW{1'b0}};
                  sweepOn_reg <= 1'b1;
                  count_reg <= MASS_CYC;
                end else begin
                  evSet[`FCS_ST_FAIL] <= 1'b1;
                end
              end
              `FCS_CMD_SIGN: begin
                sweep_reg <= {`FCS_AW{1'b0}};
                flash_signature_reg <= 24'h00_0000;
                sweepOn_reg <= 1'b1;
                state_reg <= S_SIGN;
                count_reg <= SIGN_CYC;
              end
              `FCS_CMD_PROTECT: begin
                if (protectUsed_reg) evSet[`FCS_ST_FAIL] <= 1'b1;
                else protectUsed_reg <= 1'b1;
              end
              // reserved codes do nothing
              // They still raise fail and done, so software is not left polling.
              default: evSet[`FCS_ST_FAIL] <= 1'b1;
            endcase
          end
        end
        S_WAIT: begin
          // Erase sweeps one word a cycle; the longer of sweep and timer sets the total length.
          if (sweepOn_reg) begin
            if (!(cmd_reg == `FCS_CMD_MASS && sweep_reg >= `FCS_KERNEL_BASE))
              flashMem[sweep_reg] <= 16'hFFFF;
            if ((cmd_reg == `FCS_CMD_MASS) ? (sweep_reg == {`FCS_AW{1'b1}})
                                           : (sweep_reg == pageLast)) begin
              sweepOn_reg <= 1'b0;
              if (cmd_reg == `FCS_CMD_MASS) begin
                flash_protection_value <= 32'hFFFF_FFFF;
                protectUsed_reg <= 1'b0;
              end
            end
            sweep_reg <= sweep_reg + 1'b1;
          end else if (cmd_reg == `FCS_CMD_ERWR && count_reg <= 32'h0000_0001) begin
            // program after erase
            // Done on the last cycle, once both sweep and timer have ended.
            flashMem[wordAddr] <= flash_data_reg;
          end
          if (count_reg <= 32'h0000_0001 && !sweepOn_reg) state_reg <= S_DONE;
          else if (count_reg > 32'h0000_0001) count_reg <= count_reg - 32'h0000_0001;
        end
        S_SIGN: begin
          // Rolling 24-bit checksum of every word once, the last included,
          // then pad to the cycle count.
          if (sweepOn_reg) begin
            flash_signature_reg <= {flash_signature_reg[22:0], flash_signature_reg[23]}
                                   ^ {8'h00, flashMem[sweep_reg]};
            if (sweep_reg == {`FCS_AW{1'b1}}) sweepOn_reg <= 1'b0;
            else sweep_reg <= sweep_reg + 1'b1;
          end
          if (count_reg <= 32'h0000_0001 && !sweepOn_reg) state_reg <= S_DONE;
          else if (count_reg > 32'h0000_0001) count_reg <= count_reg - 32'h0000_0001;
        end
        S_DONE: begin
          evSet[`FCS_ST_DONE] <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Status: sticky events, write one to clear, set wins over clear.
  // Letting the set win means an event that lands with its own clear is
  // never lost. Busy is computed ahead so it rises with the command edge.
  // ==========================================================
  always @(posedge core_clk) begin
    if (!resetn) begin
      status_reg <= 4'h0;
      irq        <= 1'b0;
    end else if (clkEn) begin
      status_reg[`FCS_ST_BUSY] <= ~(state_reg == S_IDLE && !(cmdWrite && mode_reg[0]));
      status_reg[`FCS_ST_DONE] <= evSet[`FCS_ST_DONE] |
        (status_reg[`FCS_ST_DONE] & ~(busWr && regAddr_reg == `FCS_OFF_STATUS && hwdata[0]));
      status_reg[`FCS_ST_VERIFY] <= evSet[`FCS_ST_VERIFY] |
        (status_reg[`FCS_ST_VERIFY] & ~(busWr && regAddr_reg == `FCS_OFF_STATUS && hwdata[1]));
      status_reg[`FCS_ST_FAIL] <= evSet[`FCS_ST_FAIL] |
        (status_reg[`FCS_ST_FAIL] & ~(busWr && regAddr_reg == `FCS_OFF_STATUS && hwdata[3]));
      irq <= |(status_reg & irqMask_reg & `FCS_ST_STICKY);
    end
  end

endmodule
`default_nettype wire

// [verilog/fcs_defines.vh]
// Functional notes
// - Read loads addressed word into data register
// - Write programs data register, about fifty microseconds
// - Erase page then program, about 24 ms
// - Verify compares, result in status bit one
// - Page erase clears only the addressed page
// - Mass erase clears user region, keeps kernel
// - Mass erase needs preceding key sequence
// - Reserved codes perform no flash operation
// - Signature over whole flash, 32778 cycles
// - Protect runs once; cleared only by mass erase (the code also clears it on reset)
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// ==========================================================
// Register byte offsets on the bus.
// ==========================================================
`define FCS_OFF_STATUS    8'h00
`define FCS_OFF_MODE      8'h04
`define FCS_OFF_COMMAND   8'h08
`define FCS_OFF_DATA      8'h0C
`define FCS_OFF_ADDRESS   8'h10
`define FCS_OFF_SIGNATURE 8'h14
`define FCS_OFF_PROTECT   8'h18
`define FCS_OFF_IRQ_MASK  8'h1C
`define FCS_OFF_KEY       8'h20

// ==========================================================
// Status bit positions; the interrupt mask shares this layout.
// ==========================================================
`define FCS_ST_DONE    0
`define FCS_ST_VERIFY  1
`define FCS_ST_BUSY    2
`define FCS_ST_FAIL    3
`define FCS_ST_STICKY  4'h9

// ==========================================================
// Command codes.
// ==========================================================
`define FCS_CMD_READ    4'h1
`define FCS_CMD_WRITE   4'h2
`define FCS_CMD_ERWR    4'h3
`define FCS_CMD_VERIFY  4'h4
`define FCS_CMD_PGERASE 4'h5
`define FCS_CMD_MASS    4'h6
`define FCS_CMD_SIGN    4'hB
`define FCS_CMD_PROTECT 4'hC

// Value software writes to the key register to arm a mass erase.
`define FCS_MASS_KEY    16'hF456

// ==========================================================
// Timing, in the units printed, and the clock period in ns.
// ==========================================================
`define FCS_CLK_NS      100
`define FCS_WRITE_US    50
`define FCS_ERWR_MS     24
`define FCS_MASS_MS     2480
`define FCS_SIGN_CYC    32778
`define FCS_ERASE_MS    24

// Geometry: 16-bit words, 512-byte pages, 64 kB array, kernel top 2 kB.
`define FCS_AW          15
`define FCS_PAGE_SH     8
`define FCS_KERNEL_BASE 15'h7C00

`endif

// [dv/fcs_flash_command_sequencer_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"
// ==========================================================
// Bus-side checks; only the top module's ports are visible.
// ==========================================================
module fcs_flash_command_sequencer_checker (
  input wire        core_clk,
  input wire        resetn,
  input wire        clkEn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        irq
);
  // A read address phase accepted at this edge.
  wire rdTaken = clkEn && hsel && htrans[1] && hready && !hwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_reset; $rose(resetn) |-> hrdata == 32'h0000_0000 && !irq; endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  // Read data stands for exactly the one data phase.
  property p_idle; $past(clkEn) && !$past(rdTaken) |-> hrdata == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside data phase");
  property p_unmap; $past(rdTaken) && $past(haddr) >= 32'h0000_0024 |-> hrdata == 0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_data;
    $past(rdTaken) && $past(haddr[7:0]) == `FCS_OFF_DATA |-> hrdata[31:16] == 16'h0000;
  endproperty
  a_data: assert property (p_data) else $error("data word wider than 16 bits");
  property p_sign;
    $past(rdTaken) && $past(haddr[7:0]) == `FCS_OFF_SIGNATURE |-> hrdata[31:24] == 8'h00;
  endproperty
  a_sign: assert property (p_sign) else $error("signature wider than 24 bits");
  property p_stat;
    $past(rdTaken) && $past(haddr[7:0]) == `FCS_OFF_STATUS |-> hrdata[31:4] == 28'h000_0000;
  endproperty
  a_stat: assert property (p_stat) else $error("status upper bits set");
  c_irq: cover property ($rose(irq));
  c_busy: cover property ($past(rdTaken) && $past(haddr[7:0]) == `FCS_OFF_STATUS && hrdata[2]);
  c_sign: cover property ($past(rdTaken) && $past(haddr[7:0]) == `FCS_OFF_SIGNATURE);
endmodule
bind fcs_flash_command_sequencer fcs_flash_command_sequencer_checker chk (
  .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
`default_nettype wire

// [dv/fcs_flash_command_sequencer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"
module fcs_flash_command_sequencer_bench;
  reg         core_clk = 1'b0;
  reg         resetn   = 1'b0;
  reg         hsel     = 1'b0;
  reg  [31:0] haddr    = 32'h0000_0000;
  reg  [1:0]  htrans   = 2'h0;
  reg         hwrite   = 1'b0;
  reg  [31:0] hwdata   = 32'h0000_0000;
  reg  [2:0]  hsize    = 3'h2;
  reg         clkEn    = 1'b1;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        irq;
  integer     errors   = 0;
  integer     testsRun = 0;
  integer     cycles   = 0;
  reg  [31:0] rd;
  reg  [31:0] st;
  reg  [23:0] expSig;
  integer     i;
  // Short counts keep the run brief; erases still sweep the array.
  fcs_flash_command_sequencer #(.WRITE_CYC(20), .ERWR_CYC(20), .ERASE_CYC(20),
    .MASS_CYC(20)) uut (
    .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
  always #50 core_clk = ~core_clk;
  // ==========================================================
  // Verdict and hang guard.
  // ==========================================================
  task closeOut;
    begin
      $display("Comparisons %0d, mismatches %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // Mass erase and signature each walk 32768 words; the ceiling allows both.
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 80000) begin
      errors = errors + 1;
      closeOut;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      testsRun = testsRun + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // ==========================================================
  // One single word transfer; the answer is awaited, not assumed.
  // ==========================================================
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hsize <= 3'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      q = hrdata;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask
  task rdChk(input [7:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0000_0000, rd);
      check(rd, exp);
    end
  endtask
  // Polls until done and idle; the status seen is kept in st.
  task waitDone;
    do xfer(1'b0, `FCS_OFF_STATUS, 32'h0000_0000, st); while (st[0] !== 1'b1 || st[2] !== 1'b0);
  endtask
  task runCmd(input [3:0] c);
    begin
      wr(`FCS_OFF_COMMAND, {28'h000_0000, c});
      waitDone;
      wr(`FCS_OFF_STATUS, 32'h0000_000B);
    end
  endtask
  task readAt(input [15:0] a, input [15:0] exp);
    begin
      wr(`FCS_OFF_ADDRESS, {16'h0000, a});
      runCmd(`FCS_CMD_READ);
      rdChk(`FCS_OFF_DATA, {16'h0000, exp});
    end
  endtask
  task prog(input [15:0] a, input [15:0] d, input [3:0] c);
    begin
      wr(`FCS_OFF_ADDRESS, {16'h0000, a});
      wr(`FCS_OFF_DATA, {16'h0000, d});
      runCmd(c);
    end
  endtask
  // ==========================================================
  // Scenarios.
  // ==========================================================
  task tReset;
    begin
      rdChk(`FCS_OFF_STATUS, 32'h0000_0000);
      rdChk(`FCS_OFF_PROTECT, 32'hFFFF_FFFF);
      rdChk(`FCS_OFF_MODE, 32'h0000_0001);
      rdChk(8'h24, 32'h0000_0000);
      // With the enable bit low a command write must be ignored.
      wr(`FCS_OFF_MODE, 32'h0000_0000);
      wr(`FCS_OFF_COMMAND, {28'h000_0000, `FCS_CMD_READ});
      rdChk(`FCS_OFF_STATUS, 32'h0000_0000);
      wr(`FCS_OFF_MODE, 32'h0000_0001);
    end
  endtask
  // Writes to data while busy must be dropped.
  task tProgram;
    begin
      wr(`FCS_OFF_ADDRESS, 32'h0000_0100);
      wr(`FCS_OFF_DATA, 32'h0000_1234);
      wr(`FCS_OFF_COMMAND, {28'h000_0000, `FCS_CMD_ERWR});
      xfer(1'b0, `FCS_OFF_STATUS, 32'h0000_0000, st);
      check(st & 32'h0000_0004, 32'h0000_0004);
      wr(`FCS_OFF_DATA, 32'h0000_BEEF);
      waitDone;
      wr(`FCS_OFF_STATUS, 32'h0000_000B);
      rdChk(`FCS_OFF_DATA, 32'h0000_1234);
      wr(`FCS_OFF_DATA, 32'h0000_0000);
      readAt(16'h0100, 16'h1234);
      prog(16'h0100, 16'h00FF, `FCS_CMD_WRITE);
      readAt(16'h0100, 16'h0034);
    end
  endtask
  // A low clock enable must stall the write timer; the AND keeps the word.
  task tFreeze;
    begin
      wr(`FCS_OFF_DATA, 32'h0000_FFFF);
      wr(`FCS_OFF_COMMAND, {28'h000_0000, `FCS_CMD_WRITE});
      clkEn <= 1'b0;
      repeat (40) @(posedge core_clk);
      clkEn <= 1'b1;
      xfer(1'b0, `FCS_OFF_STATUS, 32'h0000_0000, st);
      check(st & 32'h0000_0004, 32'h0000_0004);
      waitDone;
      wr(`FCS_OFF_STATUS, 32'h0000_000B);
    end
  endtask
  task tVerify;
    begin
      prog(16'h0100, 16'h0034, `FCS_CMD_VERIFY);
      check(st & 32'h0000_0002, 32'h0000_0000);
      prog(16'h0100, 16'h0035, `FCS_CMD_VERIFY);
      check(st & 32'h0000_0002, 32'h0000_0002);
    end
  endtask
  task tPage;
    begin
      prog(16'h0300, 16'h5555, `FCS_CMD_ERWR);
      prog(16'hF800, 16'h00AA, `FCS_CMD_ERWR);
      wr(`FCS_OFF_ADDRESS, 32'h0000_0100);
      runCmd(`FCS_CMD_PGERASE);
      readAt(16'h0100, 16'hFFFF);
      readAt(16'h0300, 16'h5555);
    end
  endtask
  task tProtect;
    begin
      wr(`FCS_OFF_PROTECT, 32'h1234_5678);
      runCmd(`FCS_CMD_PROTECT);
      check(st & 32'h0000_0008, 32'h0000_0000);
      wr(`FCS_OFF_PROTECT, 32'h0000_0000);
      runCmd(`FCS_CMD_PROTECT);
      check(st & 32'h0000_0008, 32'h0000_0008);
      rdChk(`FCS_OFF_PROTECT, 32'h1234_5678);
    end
  endtask
  task tReserved;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        runCmd(24'h789ADE >> (20 - 4 * i));
        check(st & 32'h0000_0008, 32'h0000_0008);
      end
      readAt(16'hF800, 16'h00AA);
    end
  endtask
  // Raised, cleared, then masked.
  task tIrq;
    begin
      wr(`FCS_OFF_IRQ_MASK, 32'h0000_0001);
      wr(`FCS_OFF_COMMAND, {28'h000_0000, `FCS_CMD_READ});
      waitDone;
      @(posedge core_clk);
      check({31'h0000_0000, irq}, 32'h0000_0001);
      wr(`FCS_OFF_STATUS, 32'h0000_000B);
      repeat (2) @(posedge core_clk);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      wr(`FCS_OFF_IRQ_MASK, 32'h0000_0000);
      wr(`FCS_OFF_COMMAND, {28'h000_0000, `FCS_CMD_READ});
      waitDone;
      repeat (2) @(posedge core_clk);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      wr(`FCS_OFF_STATUS, 32'h0000_000B);
    end
  endtask
  task tSign;
    begin
      // Erase the three kernel pages still unknown, so every word is known.
      for (i = 0; i < 3; i = i + 1) begin
        wr(`FCS_OFF_ADDRESS, 32'h0000_FA00 + 32'h0000_0200 * i);
        runCmd(`FCS_CMD_PGERASE);
      end
      // All words are erased except the kernel word kept by the mass erase.
      expSig = 24'h00_0000;
      for (i = 0; i < 32768; i = i + 1)
        expSig = {expSig[22:0], expSig[23]}
                 ^ ((i == 32'h0000_7C00) ? 24'h00_00AA : 24'h00_FFFF);
      wr(`FCS_OFF_COMMAND, {28'h000_0000, `FCS_CMD_SIGN});
      repeat (32700) @(posedge core_clk);
      xfer(1'b0, `FCS_OFF_STATUS, 32'h0000_0000, st);
      check(st & 32'h0000_0004, 32'h0000_0004);
      waitDone;
      wr(`FCS_OFF_STATUS, 32'h0000_000B);
      rdChk(`FCS_OFF_SIGNATURE, {8'h00, expSig});
    end
  endtask
  // Without the key nothing may be erased; with it the kernel survives.
  task tMass;
    begin
      wr(`FCS_OFF_COMMAND, {28'h000_0000, `FCS_CMD_MASS});
      repeat (4) @(posedge core_clk);
      do xfer(1'b0, `FCS_OFF_STATUS, 32'h0000_0000, st); while (st[2] !== 1'b0);
      wr(`FCS_OFF_STATUS, 32'h0000_000B);
      readAt(16'h0300, 16'h5555);
      wr(`FCS_OFF_KEY, {16'h0000, `FCS_MASS_KEY});
      runCmd(`FCS_CMD_MASS);
      readAt(16'h0300, 16'hFFFF);
      readAt(16'hF800, 16'h00AA);
      rdChk(`FCS_OFF_PROTECT, 32'hFFFF_FFFF);
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    tReset;
    tProgram;
    tFreeze;
    tVerify;
    tPage;
    tProtect;
    tReserved;
    tIrq;
    tMass;
    tSign;
    closeOut;
  end
endmodule
`default_nettype wire
